// ---- hw/rvs_pkg.sv ----
// shared constants for the regulator voltage and sequencing register bank
package rvs_pkg;
    // register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_CH6_TARGET = 8'h09;
    localparam logic [7:0] ADDR_CH7_TARGET = 8'h0a;
    localparam logic [7:0] ADDR_SLOT_CH12 = 8'h0b;
    localparam logic [7:0] ADDR_SLOT_CH34 = 8'h0c;
    localparam logic [7:0] ADDR_SLOT_CH56 = 8'h0d;
    localparam logic [7:0] ADDR_SEQUENCING = 8'h0f;
    // reset values
    localparam logic [7:0] RST_CH7_TARGET = 8'hb3;
    localparam logic [7:0] RST_CH6_TARGET = 8'h00;
    localparam logic [2:0] RST_SLOT_CODE = 3'h0;
    localparam logic [1:0] RST_SPEED = 2'h0;
    // field layout
    localparam int CODE_W = 3;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 3;
    localparam int SPEED_LSB = 6;
    localparam int CMD_LSB = 4;
    localparam int NUM_CH = 6;
    // sequence commands and slot codes
    localparam logic [1:0] CMD_UP = 2'h1;
    localparam logic [1:0] CMD_DOWN = 2'h2;
    localparam logic [2:0] SLOT_OFF = 3'h0;
    localparam logic [2:0] SLOT_FIRST = 3'h1;
    localparam logic [2:0] SLOT_LAST = 3'h7;
    // code-to-voltage mapping: mv = BASE_MV + (code - CODE_MIN) * STEP_MV
    localparam logic [7:0] CODE_MIN = 8'h10;
    localparam int BASE_MV = 1500;
    localparam int STEP_MV = 8;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLOT_UNIT_US = 500;
    localparam int SLOT_UNIT_CYCLES = SLOT_UNIT_US * 1000 / CLK_PERIOD_NS;
    localparam int SLOT_CNT_W = 17;
    // sequencer states, gray along idle-up and idle-down
    typedef enum logic [1:0] {
        RVS_IDLE = 2'b00,
        RVS_UP = 2'b01,
        RVS_DOWN = 2'b10
    } rvs_state_t;
endpackage

// ---- hw/rvs_regs.sv ----
// regulator target-voltage and sequencing-slot register bank with slot sequencer
`timescale 1ns/10ps
module rvs_regs #(
    parameter int SLOT_UNIT_CYCLES = rvs_pkg::SLOT_UNIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [rvs_pkg::NUM_CH-1:0] sw_enable_i,
    output logic [7:0] reg_rdata_o,
    output logic [7:0] ch6_target_code_o,
    output logic [7:0] ch7_target_code_o,
    output logic [1:0] target_reserved_o,
    output logic [rvs_pkg::NUM_CH-1:0] ch_enable_o,
    output logic seq_on_o,
    output logic [2:0] seq_slot_o
);
    logic [2:0] slot_code [rvs_pkg::NUM_CH];
    logic [1:0] seq_speed;
    logic seq_on;
    logic [2:0] cur_slot;
    logic [rvs_pkg::NUM_CH-1:0] seq_en;
    rvs_pkg::rvs_state_t state;
    rvs_pkg::rvs_state_t next_state;
    logic [2:0] next_slot;
    logic next_seq_on;
    logic [rvs_pkg::NUM_CH-1:0] next_seq_en;
    logic [rvs_pkg::NUM_CH-1:0] slot_hit;
    logic [rvs_pkg::NUM_CH-1:0] next_ch_enable;
    logic tick;

    // write decode
    logic wr_ch6;
    logic wr_ch7;
    logic wr_seqctl;
    logic cmd_up;
    logic cmd_down;
    logic [1:0] wr_cmd;
    assign wr_ch6 = reg_wr_i && (reg_addr_i == rvs_pkg::ADDR_CH6_TARGET);
    assign wr_ch7 = reg_wr_i && (reg_addr_i == rvs_pkg::ADDR_CH7_TARGET);
    assign wr_seqctl = reg_wr_i && (reg_addr_i == rvs_pkg::ADDR_SEQUENCING);
    assign wr_cmd = reg_wdata_i[rvs_pkg::CMD_LSB +: 2];
    assign cmd_up = wr_seqctl && (wr_cmd == rvs_pkg::CMD_UP);
    assign cmd_down = wr_seqctl && (wr_cmd == rvs_pkg::CMD_DOWN);

    // target codes, all 8 bits stored so 0xff reaches the top step; reserved codes kept as
    // written and only flagged, since blocking them would hide a host mistake
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ch6_target_code_o <= rvs_pkg::RST_CH6_TARGET;
            ch7_target_code_o <= rvs_pkg::RST_CH7_TARGET;
            target_reserved_o <= 2'h0;
        end else begin
            if (wr_ch6) ch6_target_code_o <= reg_wdata_i;
            if (wr_ch7) ch7_target_code_o <= reg_wdata_i;
            target_reserved_o <= {ch7_target_code_o < rvs_pkg::CODE_MIN,
                                  ch6_target_code_o < rvs_pkg::CODE_MIN};
        end
    end

    // slot codes, two per register; bits 7:6 are never stored
    genvar gi;
    generate
        for (gi = 0; gi < rvs_pkg::NUM_CH; gi++) begin : g_slot
            localparam logic [7:0] REG_ADDR = rvs_pkg::ADDR_SLOT_CH12 + 8'(gi / 2);
            localparam int FLD_LSB = (gi % 2 == 1) ? rvs_pkg::HI_LSB : rvs_pkg::LO_LSB;
            logic wr_here;
            assign wr_here = reg_wr_i && (reg_addr_i == REG_ADDR);
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    slot_code[gi] <= rvs_pkg::RST_SLOT_CODE;
                end else if (wr_here) begin
                    slot_code[gi] <= reg_wdata_i[FLD_LSB +: rvs_pkg::CODE_W];
                end
            end
            // channels whose code matches the slot being entered switch together
            assign slot_hit[gi] = (slot_code[gi] != rvs_pkg::SLOT_OFF) &&
                                  (slot_code[gi] == next_slot);
            // code 000 hands the channel to its software enable
            assign next_ch_enable[gi] = (slot_code[gi] == rvs_pkg::SLOT_OFF) ?
                                        sw_enable_i[gi] : next_seq_en[gi];
        end
    endgenerate

    // speed field
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            seq_speed <= rvs_pkg::RST_SPEED;
        end else if (wr_seqctl) begin
            seq_speed <= reg_wdata_i[rvs_pkg::SPEED_LSB +: 2];
        end
    end

    rvs_slot_timer #(
        .UNIT_CYCLES(SLOT_UNIT_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .restart_i(cmd_up || cmd_down),
        .speed_i(seq_speed),
        .tick_o(tick)
    );

    // sequencer next state; a new command overrides one in progress, code 11 is ignored
    always_comb begin
        next_state = state;
        next_slot = cur_slot;
        next_seq_on = seq_on;
        if (cmd_up) begin
            next_state = rvs_pkg::RVS_UP;
            next_slot = rvs_pkg::SLOT_FIRST;
            next_seq_on = 1'b1;
        end else if (cmd_down) begin
            next_state = rvs_pkg::RVS_DOWN;
            next_slot = rvs_pkg::SLOT_LAST;
            next_seq_on = 1'b0;
        end else if (tick) begin
            unique case (state)
                rvs_pkg::RVS_IDLE: begin
                    next_state = rvs_pkg::RVS_IDLE;
                end
                rvs_pkg::RVS_UP: begin
                    if (cur_slot == rvs_pkg::SLOT_LAST) begin
                        next_state = rvs_pkg::RVS_IDLE;
                        next_slot = rvs_pkg::SLOT_OFF;
                    end else begin
                        next_slot = cur_slot + 3'h1;
                    end
                end
                rvs_pkg::RVS_DOWN: begin
                    if (cur_slot == rvs_pkg::SLOT_FIRST) begin
                        next_state = rvs_pkg::RVS_IDLE;
                        next_slot = rvs_pkg::SLOT_OFF;
                    end else begin
                        next_slot = cur_slot - 3'h1;
                    end
                end
                default: begin
                    next_state = rvs_pkg::RVS_IDLE;
                    next_slot = rvs_pkg::SLOT_OFF;
                end
            endcase
        end
    end

    // enables gathered while stepping; only the slot being entered changes
    always_comb begin
        next_seq_en = seq_en;
        if (next_state == rvs_pkg::RVS_UP && (cmd_up || next_slot != cur_slot)) begin
            next_seq_en = seq_en | slot_hit;
        end else if (next_state == rvs_pkg::RVS_DOWN && (cmd_down || next_slot != cur_slot)) begin
            next_seq_en = seq_en & ~slot_hit;
        end
    end

    // sequencer registers and enable outputs
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state <= rvs_pkg::RVS_IDLE;
            cur_slot <= rvs_pkg::SLOT_OFF;
            seq_on <= 1'b0;
            seq_en <= '0;
            ch_enable_o <= '0;
        end else begin
            state <= next_state;
            cur_slot <= next_slot;
            seq_on <= next_seq_on;
            seq_en <= next_seq_en;
            ch_enable_o <= next_ch_enable;
        end
    end

    // read mux; unused bits and command field read zero
    logic [7:0] rd_mux;
    assign rd_mux =
        (reg_addr_i == rvs_pkg::ADDR_CH6_TARGET) ? ch6_target_code_o :
        (reg_addr_i == rvs_pkg::ADDR_CH7_TARGET) ? ch7_target_code_o :
        (reg_addr_i == rvs_pkg::ADDR_SLOT_CH12) ? {2'h0, slot_code[1], slot_code[0]} :
        (reg_addr_i == rvs_pkg::ADDR_SLOT_CH34) ? {2'h0, slot_code[3], slot_code[2]} :
        (reg_addr_i == rvs_pkg::ADDR_SLOT_CH56) ? {2'h0, slot_code[5], slot_code[4]} :
        (reg_addr_i == rvs_pkg::ADDR_SEQUENCING) ? {seq_speed, 2'h0, seq_on, cur_slot} :
        8'h00;

    // read data held until the next read strobe
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
            seq_on_o <= 1'b0;
            seq_slot_o <= 3'h0;
        end else begin
            if (reg_rd_i) reg_rdata_o <= rd_mux;
            seq_on_o <= seq_on;
            seq_slot_o <= cur_slot;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_ch7_write: assert property (wr_ch7 |=> ch7_target_code_o == $past(reg_wdata_i))
        else $error("channel 7 target not stored");
    a_ch6_write: assert property (wr_ch6 |=> ch6_target_code_o == $past(reg_wdata_i))
        else $error("channel 6 target not stored");
    a_reserved_flag: assert property (##1 target_reserved_o[1] ==
        ($past(ch7_target_code_o) < rvs_pkg::CODE_MIN))
        else $error("reserved flag wrong");
    a_unused_zero: assert property (reg_rd_i && reg_addr_i == rvs_pkg::ADDR_SLOT_CH56
        |=> reg_rdata_o[7:6] == 2'h0) else $error("unused bits read nonzero");
    a_ch1_field: assert property (reg_wr_i && reg_addr_i == rvs_pkg::ADDR_SLOT_CH12
        |=> slot_code[0] == $past(reg_wdata_i[2:0])) else $error("channel 1 slot not stored");
    a_sw_passthru: assert property (slot_code[2] == rvs_pkg::SLOT_OFF
        |=> ch_enable_o[2] == $past(sw_enable_i[2])) else $error("software enable lost");
    a_up_start: assert property (cmd_up |=> state == rvs_pkg::RVS_UP &&
        cur_slot == rvs_pkg::SLOT_FIRST && seq_on) else $error("power-up did not start");
    a_down_start: assert property (cmd_down |=> state == rvs_pkg::RVS_DOWN &&
        cur_slot == rvs_pkg::SLOT_LAST && !seq_on) else $error("shutdown did not start");
    a_slot_ascend: assert property (state == rvs_pkg::RVS_UP && tick && !wr_seqctl &&
        cur_slot != rvs_pkg::SLOT_LAST |=> cur_slot == $past(cur_slot) + 3'h1)
        else $error("slot did not advance");
    a_slot_enable: assert property (state == rvs_pkg::RVS_UP &&
        $changed(cur_slot) && slot_code[0] != rvs_pkg::SLOT_OFF && slot_code[0] == cur_slot &&
        $stable(slot_code[0]) |-> seq_en[0]) else $error("slotted channel off");

    c_up_seq: cover property (cmd_up ##[1:1000] state == rvs_pkg::RVS_UP && tick);
    c_down_seq: cover property (cmd_down ##1 state == rvs_pkg::RVS_DOWN);
    c_up_done: cover property (state == rvs_pkg::RVS_UP ##1 state == rvs_pkg::RVS_IDLE);
endmodule

// ---- hw/rvs_slot_timer.sv ----
// slot period timer for the power sequencer
`timescale 1ns/10ps
module rvs_slot_timer #(
    parameter int UNIT_CYCLES = rvs_pkg::SLOT_UNIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic restart_i,
    input wire logic [1:0] speed_i,
    output logic tick_o
);
    logic [rvs_pkg::SLOT_CNT_W-1:0] cnt;
    logic [rvs_pkg::SLOT_CNT_W-1:0] period_last;
    logic at_last;

    // slot length is (speed + 1) units of 500 us; >= stops a speed change in mid-slot
    // from letting the count run on past the new end
    assign period_last = rvs_pkg::SLOT_CNT_W'((int'(speed_i) + 1) * UNIT_CYCLES - 1);
    assign at_last = (cnt >= period_last);
    // tick straight from the compare, so the first slot is no longer than the others
    assign tick_o = at_last && !restart_i;

    // restart realigns the slot grid to the command
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt <= '0;
        end else begin
            cnt <= (restart_i || at_last) ? '0 : cnt + 1'b1;
        end
    end
endmodule

// ---- verif/rvs_host_model.sv ----
// host-side byte port driver standing in for the serial register engine
`timescale 1ns/10ps
module rvs_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // quiet port at time zero, before reset ends
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle write strobe; callers never pass reserved target codes
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a; // stale bus shows inverted values, not the last ones
        wdata_o <= ~d;
    endtask

    // one-cycle read strobe, data taken two cycles after the strobe is raised
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask
endmodule

// ---- verif/test_regulator_voltage_sequence_regs.sv ----
// self-checking bench for the regulator target and sequencing register bank
`timescale 1ns/10ps
module test_regulator_voltage_sequence_regs;
    localparam int UNIT = 4;
    logic clk_i;
    logic nrst_i;
    logic [5:0] sw_enable_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic [7:0] ch6_o;
    logic [7:0] ch7_o;
    logic [1:0] rsv_o;
    logic [5:0] en_o;
    logic seq_on_o;
    logic [2:0] slot_o;
    logic [7:0] rd;
    int bad_count;
    int total_checks;
    // ch1 and ch3 share slot 1 on purpose, ch5 stays manual
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h1, 3'h7, 3'h0, 3'h3};

    rvs_regs #(.SLOT_UNIT_CYCLES(UNIT)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .sw_enable_i(sw_enable_i), .reg_rdata_o(reg_rdata_o),
        .ch6_target_code_o(ch6_o), .ch7_target_code_o(ch7_o), .target_reserved_o(rsv_o),
        .ch_enable_o(en_o), .seq_on_o(seq_on_o), .seq_slot_o(slot_o));

    rvs_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        host.read(a, rd);
        check(what, rd, exp);
    endtask

    // enables expected once every slot up to hi has been visited
    function automatic logic [5:0] expect_en(input int hi);
        logic [5:0] e;
        e = sw_enable_i;
        for (int i = 0; i < 6; i++) begin
            if (codes[i] != 3'h0 && int'(codes[i]) <= hi) begin
                e[i] = 1'b1;
            end
        end
        return e;
    endfunction

    task automatic t_reset();
        rd_chk(rvs_pkg::ADDR_CH6_TARGET, 8'h00, "ch6 reset");
        rd_chk(rvs_pkg::ADDR_CH7_TARGET, 8'hb3, "ch7 reset");
        rd_chk(rvs_pkg::ADDR_SLOT_CH12, 8'h00, "slot12 reset");
        rd_chk(rvs_pkg::ADDR_SLOT_CH34, 8'h00, "slot34 reset");
        rd_chk(rvs_pkg::ADDR_SLOT_CH56, 8'h00, "slot56 reset");
        check("enables reset", {2'h0, en_o}, 8'h00);
        // ch6 resets to code 0x00, which is reserved, so its flag must be up
        check("reserved at reset", {6'h00, rsv_o}, 8'h01);
        $display("test reset done");
    endtask

    // extreme usable codes, written back to back
    task automatic t_targets();
        host.write(rvs_pkg::ADDR_CH6_TARGET, 8'hff);
        host.write(rvs_pkg::ADDR_CH7_TARGET, 8'h10);
        rd_chk(rvs_pkg::ADDR_CH6_TARGET, 8'hff, "ch6 code");
        rd_chk(rvs_pkg::ADDR_CH7_TARGET, 8'h10, "ch7 code");
        check("ch6 port", ch6_o, 8'hff);
        check("ch7 port", ch7_o, 8'h10);
        check("reserved flags", {6'h00, rsv_o}, 8'h00);
        rd_chk(8'h20, 8'h00, "unmapped read");
        $display("test targets done");
    endtask

    task automatic t_slots();
        host.write(rvs_pkg::ADDR_SLOT_CH12, 8'hff);
        rd_chk(rvs_pkg::ADDR_SLOT_CH12, 8'h3f, "slot12 all ones");
        host.write(rvs_pkg::ADDR_SLOT_CH12, {2'h3, codes[1], codes[0]});
        host.write(rvs_pkg::ADDR_SLOT_CH34, {2'h0, codes[3], codes[2]});
        host.write(rvs_pkg::ADDR_SLOT_CH56, {2'h0, codes[5], codes[4]});
        rd_chk(rvs_pkg::ADDR_SLOT_CH12, 8'h11, "slot12");
        rd_chk(rvs_pkg::ADDR_SLOT_CH34, 8'h39, "slot34");
        rd_chk(rvs_pkg::ADDR_SLOT_CH56, 8'h18, "slot56");
        check("no enable from codes", {2'h0, en_o}, 8'h00);
        @(posedge clk_i);
        sw_enable_i <= 6'h10;
        repeat (2) @(posedge clk_i);
        #1;
        check("manual ch5", {2'h0, en_o}, 8'h10);
        $display("test slots done");
    endtask

    task automatic t_power_up();
        host.write(rvs_pkg::ADDR_SEQUENCING, {2'h0, rvs_pkg::CMD_UP, 4'h0});
        for (int s = 1; s <= 8; s++) begin
            repeat ((s == 1) ? 1 : UNIT) @(posedge clk_i);
            #1;
            check("up slot", {5'h00, slot_o}, 8'(s % 8));
            check("up enables", {2'h0, en_o}, {2'h0, expect_en(s > 7 ? 7 : s)});
        end
        check("seq on", {7'h00, seq_on_o}, 8'h01);
        rd_chk(rvs_pkg::ADDR_SEQUENCING, 8'h08, "status up");
        $display("test power up done");
    endtask

    // slower speed code doubles the slot period
    task automatic t_power_down();
        host.write(rvs_pkg::ADDR_SEQUENCING, {2'h1, rvs_pkg::CMD_DOWN, 4'h0});
        for (int k = 7; k >= 0; k--) begin
            repeat ((k == 7) ? 1 : 2 * UNIT) @(posedge clk_i);
            #1;
            check("down slot", {5'h00, slot_o}, 8'(k));
            check("down enables", {2'h0, en_o}, {2'h0, expect_en(k == 0 ? 0 : k - 1)});
            check("seq off", {7'h00, seq_on_o}, 8'h00);
        end
        host.write(rvs_pkg::ADDR_SEQUENCING, 8'h70);
        rd_chk(rvs_pkg::ADDR_SEQUENCING, 8'h40, "command 11 ignored");
        check("enables after 11", {2'h0, en_o}, 8'h10);
        $display("test power down done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence, reset held for ten cycles
    initial begin
        bad_count = 0;
        total_checks = 0;
        nrst_i = 1'b0;
        sw_enable_i = 6'h00;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_targets();
        t_slots();
        t_power_up();
        t_power_down();
        end_of_test();
    end

    // watchdog against a hung sequence
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule
